// >>> design/asrc_pkg.sv
// What this block does
// - Shared data lines; host drives only writes.
// - Every cycle lasts at least 200 ns.
// - Select 120, write 140, data 80 ns.
package asrc_pkg;

  localparam int CLK_PERIOD_NS = 50;
  localparam int ADDR_W        = 10;
  localparam int DATA_W        = 4;

  localparam int CYCLE_NS      = 200;
  localparam int ACCESS_NS     = 200;
  localparam int CS_TO_END_NS  = 120;
  localparam int WPULSE_NS     = 140;
  localparam int DSETUP_NS     = 80;
  localparam int FLOAT_NS      = 80;

  // Least times round up to whole cycles.
  localparam int CYCLE_CYC  = (CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CSW_CYC    = (CS_TO_END_NS + CLK_PERIOD_NS - 1)
                              / CLK_PERIOD_NS;
  localparam int WP_CYC     = (WPULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DS_CYC     = (DSETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLOAT_CYC  = (FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Spare cycle past the access time, and the input synchroniser depth.
  localparam int MARGIN_CYC  = 1;
  localparam int SYNC_STAGES = 2;

  localparam int CNT_W = 4;

  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } asrc_req_t;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_READ  = 5'h02,
    ST_WRITE = 5'h04,
    ST_HOLD  = 5'h08,
    ST_TURN  = 5'h10
  } asrc_state_t;

endpackage

// >>> design/asrc_host.sv
module asrc_host
  import asrc_pkg::*;
#(
  // Timing counts, in clock cycles
  parameter int RD_CYCLES   = ACCESS_CYC,
  parameter int WR_CYCLES   = CYCLE_CYC,
  parameter int TURN_CYCLES = FLOAT_CYC,
  // Cycle counter width
  parameter int CNT_BITS    = CNT_W
)
(
  // Clock and reset
  input  wire logic              CLK,
  input  wire logic              NRST,
  // User request side
  input  wire logic              REQ_VALID,
  input  wire asrc_req_t         REQ,
  output logic                   REQ_READY,
  output logic                   RD_VALID,
  output logic [DATA_W-1:0]      RD_DATA,
  // Memory pins
  output logic [ADDR_W-1:0]      MEM_A,
  output logic                   MEM_CE_N,
  output logic                   MEM_WE_N,
  input  wire logic [DATA_W-1:0] MEM_DQ_I,
  output logic [DATA_W-1:0]      MEM_DQ_O,
  output logic                   MEM_DQ_OE
);

  asrc_state_t         state_reg;
  asrc_state_t         state_next;
  logic [CNT_BITS-1:0] cnt_reg;
  logic [CNT_BITS-1:0] cnt_next;
  logic [DATA_W-1:0]   dq_s1_reg;
  logic [DATA_W-1:0]   dq_s2_reg;
  logic                take;
  logic                rd_done;
  logic                wr_done;
  logic                turn_done;

  function automatic int longest(int x, int y);
    return (x > y) ? x : y;
  endfunction

  function automatic logic reached(logic [CNT_BITS-1:0] cnt, int last);
    return cnt >= CNT_BITS'(last);
  endfunction

  // Sampling right at the access limit would race the data pins, so a
  // read waits one spare cycle and then the synchroniser delay.
  localparam int RD_LAST = RD_CYCLES + MARGIN_CYC + SYNC_STAGES;
  localparam int WR_LAST = longest(longest(WR_CYCLES, WP_CYC),
                                   longest(CSW_CYC, DS_CYC));

  if (RD_CYCLES < ACCESS_CYC || WR_CYCLES < CYCLE_CYC
      || TURN_CYCLES < FLOAT_CYC)
  begin
    $error("Timing counts are below the memory minimum.");
  end

  if (CNT_BITS < 2 || CNT_BITS > 16
      || longest(RD_LAST, WR_LAST) >= (1 << CNT_BITS))
  begin
    $error("Cycle counter is too narrow for the timing counts.");
  end

  always_comb
  begin
    take      = (state_reg == ST_IDLE) && REQ_VALID && REQ_READY;
    rd_done   = (state_reg == ST_READ) && reached(cnt_reg, RD_LAST);
    wr_done   = (state_reg == ST_WRITE) && reached(cnt_reg, WR_LAST);
    turn_done = (state_reg == ST_TURN) && reached(cnt_reg, TURN_CYCLES);
  end

  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg + CNT_BITS'(1);
    unique case (state_reg)
      ST_IDLE:
      begin
        cnt_next = CNT_BITS'(1);
        if (take)
        begin
          state_next = REQ.write ? ST_WRITE : ST_READ;
        end
      end
      ST_READ:
      begin
        if (rd_done)
        begin
          cnt_next   = CNT_BITS'(1);
          state_next = ST_TURN;
        end
      end
      ST_WRITE:
      begin
        if (wr_done)
        begin
          state_next = ST_HOLD;
        end
      end
      ST_HOLD:
      begin
        cnt_next   = CNT_BITS'(1);
        state_next = ST_TURN;
      end
      ST_TURN:
      begin
        // Wait for the memory to float before anyone drives again.
        if (turn_done)
        begin
          state_next = ST_IDLE;
        end
      end
      default:
      begin
        cnt_next   = CNT_BITS'(1);
        state_next = ST_IDLE;
      end
    endcase
  end

  // The read pins pass two flops; the sample point is stretched to match.
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      dq_s1_reg <= '0;
      dq_s2_reg <= '0;
    end
    else
    begin
      dq_s1_reg <= MEM_DQ_I;
      dq_s2_reg <= dq_s1_reg;
    end
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      state_reg <= ST_IDLE;
      cnt_reg   <= '0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      REQ_READY <= 1'b0;
    end
    else
    begin
      REQ_READY <= (state_reg == ST_IDLE) && !take;
    end
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      RD_VALID <= 1'b0;
      RD_DATA  <= '0;
    end
    else
    begin
      RD_VALID <= rd_done;
      if (rd_done)
      begin
        RD_DATA <= dq_s2_reg;
      end
    end
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      MEM_A <= '0;
    end
    else if (take)
    begin
      MEM_A <= REQ.addr;
    end
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      MEM_CE_N <= 1'b1;
    end
    else if (take)
    begin
      MEM_CE_N <= 1'b0;
    end
    else if (rd_done || wr_done)
    begin
      MEM_CE_N <= 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      MEM_WE_N <= 1'b1;
    end
    else if (take && REQ.write)
    begin
      // Write enable and select fall together, so the memory
      // never turns its drivers on during the write.
      MEM_WE_N <= 1'b0;
    end
    else if (wr_done)
    begin
      MEM_WE_N <= 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      MEM_DQ_O <= '0;
    end
    else if (take && REQ.write)
    begin
      MEM_DQ_O <= REQ.wdata;
    end
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      MEM_DQ_OE <= 1'b0;
    end
    else if (take)
    begin
      MEM_DQ_OE <= REQ.write;
    end
    else if (state_reg == ST_HOLD)
    begin
      // Data held one cycle past the write end for zero hold time.
      MEM_DQ_OE <= 1'b0;
    end
  end

endmodule

// >>> verif/asrc_host_monitor.sv
module asrc_host_monitor
(
  // Clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // Watched outputs
  input wire logic RD_VALID,
  input wire logic MEM_CE_N,
  input wire logic MEM_WE_N,
  input wire logic MEM_DQ_OE
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  cyc_len_a:
    assert property ($fell(MEM_CE_N) |-> !MEM_CE_N [*4]) else $error("short");
  rd_time_a:
    assert property ($fell(MEM_CE_N) && MEM_WE_N |-> ##7 RD_VALID)
      else $error("late");
  wr_pulse_a:
    assert property ($fell(MEM_WE_N) |-> !(MEM_WE_N | MEM_CE_N) [*3])
      else $error("pulse");
  dq_own_a:
    assert property (MEM_DQ_OE |-> !MEM_WE_N || !$past(MEM_WE_N))
      else $error("drive");
  cover property ($fell(MEM_WE_N));
  cover property (RD_VALID);
  cover property ($rose(MEM_CE_N));
endmodule
bind asrc_host asrc_host_monitor asrc_host_monitor_i (.CLK(CLK), .NRST(NRST),
  .RD_VALID(RD_VALID), .MEM_CE_N(MEM_CE_N), .MEM_WE_N(MEM_WE_N),
  .MEM_DQ_OE(MEM_DQ_OE));

// >>> verif/asrc_sram_model.sv
module asrc_sram_model
  import asrc_pkg::*;
(
  input  wire logic              ce_n,
  input  wire logic              we_n,
  input  wire logic              slow,
  input  wire logic [ADDR_W-1:0] a,
  input  wire logic [DATA_W-1:0] d,
  output logic      [DATA_W-1:0] q
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [DATA_W-1:0] mem [1024];
  initial q = 4'h5;
  always @(ce_n, we_n, a, d)
    if (!ce_n && !we_n)
      mem[a] = d;
  // Idle lines flip, so stale data never reads as good.
  always @(ce_n, we_n, a)
  begin
    #20 q = ~q;
    if (!ce_n && we_n)
      q <= #(slow ? 180 : 1) mem[a];
  end
endmodule

// >>> verif/asrc_host_test.sv
module asrc_host_test import asrc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic              clk = 1'h0;
  logic              nrst = 1'h0;
  logic              vld = 1'h0;
  logic              slow = 1'h0;
  asrc_req_t         req = '0;
  logic              rdy, rv, ce_n, we_n, oe;
  logic [ADDR_W-1:0] a;
  logic [DATA_W-1:0] rd, dqo, mq, dqi;
  int                miscompares = 0;
  int                n_compared = 0;
  assign dqi = oe ? dqo : mq;
  initial forever #25 clk = ~clk;
  asrc_host asrc_host_i (.CLK(clk), .NRST(nrst), .REQ_VALID(vld),
    .REQ(req), .REQ_READY(rdy), .RD_VALID(rv), .RD_DATA(rd), .MEM_A(a),
    .MEM_CE_N(ce_n), .MEM_WE_N(we_n), .MEM_DQ_I(dqi), .MEM_DQ_O(dqo),
    .MEM_DQ_OE(oe));
  asrc_sram_model asrc_sram_model_i (.ce_n(ce_n), .we_n(we_n),
    .slow(slow), .a(a), .d(dqi), .q(mq));
  task automatic check(logic [3:0] seen, logic [3:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch %0t %h %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    if (miscompares == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wait_hi(ref logic s, output int n);
    for (n = 0; s !== 1'h1; n++)
    begin
      miscompares += (n == 40);
      if (n == 40)
        results();
      @(negedge clk);
    end
  endtask
  task automatic access(logic w, logic [9:0] ad, logic [3:0] d);
    int n;
    wait_hi(rdy, n);
    vld = 1'h1;
    req = '{w, ad, d};
    @(negedge clk);
    vld = 1'h0;
    check({3'h0, rdy}, 4'h0);
    if (!w)
    begin
      wait_hi(rv, n);
      check(n[3:0], 4'h7);
      check(rd, d);
    end
  endtask
  task automatic sc_bits();
    for (int i = 0; i < 10; i++)
      access(1'h1, 10'h1 << i, i[3:0]);
    for (int i = 0; i < 10; i++)
      access(1'h0, 10'h1 << i, i[3:0]);
  endtask
  task automatic sc_slow();
    slow = 1'h1;
    access(1'h1, 10'h3ff, 4'ha);
    access(1'h1, 10'h0, 4'h5);
    access(1'h0, 10'h3ff, 4'ha);
    access(1'h0, 10'h0, 4'h5);
  endtask
  initial
  begin
    repeat (3) @(negedge clk);
    check({ce_n, we_n, oe, rdy}, 4'hc);
    nrst = 1'h1;
    sc_bits();
    sc_slow();
    results();
  end
endmodule
